//--- can_xcvr_pkg.sv
// constants and types for the transceiver mode and wake control
// assumes a single 50 MHz clock shared by every user of this package
package can_xcvr_pkg;

	typedef enum logic [3:0]
	{
		C_INIT,
		C_NORMAL,
		C_STOP,
		C_SLEEP,
		C_RESTART,
		C_FAILSAFE,
		C_SW_FLASH,
		C_SW_DEV,
		C_FACTORY_FLASH
	} chip_mode_type;

	typedef enum logic [1:0]
	{
		X_OFF,
		X_WAKE,
		X_NORMAL,
		X_RXONLY
	} xcvr_mode_type;

	// clock
	localparam int CLK_PERIOD_NS       = 20;
	localparam int CLK_FREQ_KHZ        = 50000;

	// wake filter: activity must last longer than this
	localparam int WAKE_FILTER_TIME_NS = 1000;
	localparam int WAKE_FILT_CYC       = (WAKE_FILTER_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int FILT_W              = $clog2(WAKE_FILT_CYC + 1);

	// highest bus data rate, used to pace the monitor sampler
	localparam int MAX_RATE_KBAUD      = 1000;
	localparam int BAUD_CYC            = CLK_FREQ_KHZ / MAX_RATE_KBAUD;
	localparam int BAUD_W              = $clog2(BAUD_CYC);

	// wake source register address
	localparam logic [2:0] WAKE_REG_ADDR = 3'h0;

	// reset values
	localparam logic ARMED_RST = 1'b1;
	localparam logic RXO_RST   = 1'b1;
	localparam logic INT_B_RST = 1'b1;

	// monitor fifo
	localparam int MON_W      = 2;
	localparam int MON_DEPTH  = 16;
	localparam int MON_RX_BIT = 1;
	localparam int MON_TX_BIT = 0;

endpackage

//--- can_transceiver_mode_wake_control.sv
// transceiver mode selection, bus wake detection and monitor fifo
// assumes chip mode, mode requests and bus levels are synchronous to clk
// Notes on behaviour
// - normal mode only by command, permitted chip modes
// - normal mode: bus follows the transmit input
// - receive level out; receive pin faults flagged
// - common-mode stabilization only normal or receive-only
// - wake-capable selectable; forced in fail-safe
// - wake-capable re-arms only after another mode
// - sleep wake: restart, supply up, rx low
// - wake only after activity outlasts filter time
// - sleep wake raises no interrupt; flag readable
// - stop wake: stay, interrupt, flag, rx low
// - never leaves stop mode on its own
// - fail-safe wake: flag, rx low, restart; restart-mode wake: flag, rx low
// - normal wake: stay, flag, interrupt, rx low
// - interrupt only when wake source unmasked
// - off: selectable, forced in init, ignores bus
// - paced for data rates up to 1 Mbaud
// - receive-only: driver off, receiver on
`timescale 1ns/1ps

module mon_fifo
#(
	parameter int W     = 2,
	parameter int DEPTH = 16
)
(
	input  wire logic         clk,       // system clock
	input  wire logic         rst_b,     // sync reset, active low
	input  wire logic [W-1:0] in_data,   // word to store
	input  wire logic         in_valid,  // word offered
	output logic              in_ready,  // space available
	output logic      [W-1:0] out_data,  // oldest word
	output logic              out_valid, // word available
	input  wire logic         out_ready  // drain accepts
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed
	{
		logic [AW:0] wr;
		logic [AW:0] rd;
	} fifo_state_type;

	fifo_state_type         st_r;
	fifo_state_type         st_nxt;
	logic           [W-1:0] mem_r [DEPTH];
	logic                   push;
	logic                   pop;

	assign in_ready  = (st_r.wr - st_r.rd) != (AW+1)'(DEPTH);
	assign out_valid = st_r.wr != st_r.rd;
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	assign out_data  = mem_r[st_r.rd[AW-1:0]];

	always_comb
	begin
		st_nxt = st_r;
		if (push)
			st_nxt.wr = st_r.wr + 1'b1;
		if (pop)
			st_nxt.rd = st_r.rd + 1'b1;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
			st_r <= '0;
		else
			st_r <= st_nxt;
		if (push)
			mem_r[st_r.wr[AW-1:0]] <= in_data;
	end
endmodule

module can_transceiver_mode_wake_control
#(
	parameter int MON_WIDTH = can_xcvr_pkg::MON_W,
	parameter int MON_DEP   = can_xcvr_pkg::MON_DEPTH
)
(
	input  wire logic                        clk,                // 50 MHz clock
	input  wire logic                        rst_b,              // sync reset, active low
	input  wire can_xcvr_pkg::chip_mode_type chip_mode,          // chip operating mode
	input  wire can_xcvr_pkg::xcvr_mode_type mode_req,           // requested transceiver mode
	input  wire logic                        mode_req_valid,     // request strobe
	input  wire logic                        wake_mask,          // 1 masks wake interrupt
	input  wire logic                        wake_flag_clear,    // clear wake flag and int
	input  wire logic                        rx_fault_clear,     // clear receive fault flag
	input  wire logic                        bus_transmit_input, // controller tx, 0 dominant
	input  wire logic                        bus_rx_level,       // receiver comparator out
	input  wire logic                        bus_activity,       // low-power wake receiver
	input  wire logic                        rx_pin_sense,       // receive pin readback
	output can_xcvr_pkg::xcvr_mode_type      xcvr_mode,          // current transceiver mode
	output logic                             mode_req_reject,    // request refused pulse
	output logic                             driver_enable,      // bus output stages on
	output logic                             receiver_enable,    // full receiver on
	output logic                             split_enable,       // common-mode output on
	output logic                             bus_drive_dominant, // drive bus dominant
	output logic                             bus_receive_output, // receive pin level
	output logic                             int_b,              // interrupt, active low
	output logic                             bus_wake_flag,      // sticky bus wake flag
	output logic                             rx_fault_flag,      // sticky rx pin fault
	output logic                             restart_req,        // go to restart pulse
	output logic                             mcu_supply_rail,    // supply rail enable
	output logic            [MON_WIDTH-1:0]  mon_data,           // sampled {rx, tx}
	output logic                             mon_valid,          // monitor word ready
	input  wire logic                        mon_ready           // monitor drain accepts
);
	import can_xcvr_pkg::*;

	typedef struct packed
	{
		xcvr_mode_type              mode;
		logic                       armed;
		logic                       wake_flag;
		logic                       int_pend;
		logic                       rx_hold;
		logic [FILT_W-1:0]          filt_cnt;
		logic                       restart;
		logic                       reject;
		logic                       rx_fault;
		logic                       drv;
		logic                       rxo;
		logic [BAUD_W-1:0]          baud_cnt;
		logic                       samp_pend;
		logic [MON_WIDTH-1:0]       samp_data;
		logic                       supply_ramp;
	} state_type;

	state_type st_r;
	state_type st_nxt;
	logic      wake_hit;
	logic      baud_tick;
	logic      fifo_in_ready;
	logic      low_power_chip;

	function automatic logic rx_active(input xcvr_mode_type m);
		rx_active = (m == X_NORMAL) || (m == X_RXONLY);
	endfunction

	function automatic logic mode_allowed(input chip_mode_type c, input xcvr_mode_type m,
		input logic armed);
		logic ok;
		ok = 1'b0;
		case (c)
			C_NORMAL:
				ok = 1'b1;
			C_STOP, C_SLEEP, C_RESTART:
				ok = (m == X_OFF) || (m == X_WAKE);
			C_SW_FLASH, C_SW_DEV:
				ok = (m == X_NORMAL);
			default:
				ok = 1'b0;
		endcase
		if (m == X_WAKE && !armed)
			ok = 1'b0;
		mode_allowed = ok;
	endfunction

	// off mode never counts, so bus events are ignored there
	assign wake_hit       = (st_r.mode == X_WAKE) && st_r.armed && bus_activity
		&& (st_r.filt_cnt == FILT_W'(WAKE_FILT_CYC));
	assign baud_tick      = st_r.baud_cnt == BAUD_W'(BAUD_CYC - 1);
	assign low_power_chip = (chip_mode == C_SLEEP) || (chip_mode == C_FAILSAFE);

	always_comb
	begin
		st_nxt = st_r;
		st_nxt.restart = 1'b0;
		st_nxt.reject  = 1'b0;
		case (chip_mode)
			C_INIT, C_FACTORY_FLASH:
				st_nxt.mode = X_OFF;
			C_FAILSAFE:
				st_nxt.mode = X_WAKE;
			default:
			begin
				if (mode_req_valid)
				begin
					if (mode_allowed(chip_mode, mode_req, st_r.armed))
						st_nxt.mode = mode_req;
					else
						st_nxt.reject = 1'b1;
				end
			end
		endcase
		if (st_nxt.mode != X_WAKE)
			st_nxt.armed = 1'b1;
		if (st_r.mode == X_WAKE && st_r.armed && bus_activity)
		begin
			if (st_r.filt_cnt != FILT_W'(WAKE_FILT_CYC))
				st_nxt.filt_cnt = st_r.filt_cnt + 1'b1;
		end
		else
			st_nxt.filt_cnt = '0;
		if (wake_flag_clear)
		begin
			st_nxt.wake_flag = 1'b0;
			st_nxt.int_pend  = 1'b0;
		end
		if (!low_power_chip)
			st_nxt.supply_ramp = 1'b0;
		if (rx_active(st_nxt.mode))
			st_nxt.rx_hold = 1'b0;
		if (wake_hit)
		begin
			st_nxt.wake_flag = 1'b1;
			st_nxt.armed     = 1'b0;
			st_nxt.rx_hold   = 1'b1;
			if ((chip_mode == C_STOP || chip_mode == C_NORMAL) && !wake_mask)
				st_nxt.int_pend = 1'b1;
			// stop and normal stay put; only low-power modes restart
			if (low_power_chip)
			begin
				st_nxt.restart     = 1'b1;
				st_nxt.supply_ramp = 1'b1;
			end
		end
		st_nxt.drv = (st_r.mode == X_NORMAL) && !bus_transmit_input;
		if (st_nxt.rx_hold)
			st_nxt.rxo = 1'b0;
		else if (rx_active(st_r.mode))
			st_nxt.rxo = bus_rx_level;
		else
			st_nxt.rxo = 1'b1;
		if (rx_fault_clear)
			st_nxt.rx_fault = 1'b0;
		if (rx_active(st_r.mode) && (rx_pin_sense != st_r.rxo))
			st_nxt.rx_fault = 1'b1;
		st_nxt.baud_cnt = baud_tick ? '0 : st_r.baud_cnt + 1'b1;
		// sampler stalls while its word waits for fifo space
		if (st_r.samp_pend && fifo_in_ready)
			st_nxt.samp_pend = 1'b0;
		if (baud_tick && rx_active(st_r.mode) && !st_nxt.samp_pend)
		begin
			st_nxt.samp_pend = 1'b1;
			st_nxt.samp_data = '0;
			st_nxt.samp_data[MON_RX_BIT] = bus_rx_level;
			st_nxt.samp_data[MON_TX_BIT] = bus_transmit_input;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			st_r       <= '0;
			st_r.armed <= ARMED_RST;
			st_r.rxo   <= RXO_RST;
		end
		else
			st_r <= st_nxt;
	end

	mon_fifo
	#(
		.W     (MON_WIDTH),
		.DEPTH (MON_DEP)
	)
	u_fifo
	(
		.clk       (clk),
		.rst_b     (rst_b),
		.in_data   (st_r.samp_data),
		.in_valid  (st_r.samp_pend),
		.in_ready  (fifo_in_ready),
		.out_data  (mon_data),
		.out_valid (mon_valid),
		.out_ready (mon_ready)
	);

	assign xcvr_mode          = st_r.mode;
	assign mode_req_reject    = st_r.reject;
	assign driver_enable      = st_r.mode == X_NORMAL;
	assign receiver_enable    = rx_active(st_r.mode);
	assign split_enable       = rx_active(st_r.mode);
	assign bus_drive_dominant = st_r.drv;
	assign bus_receive_output = st_r.rxo;
	assign int_b              = !st_r.int_pend;
	assign bus_wake_flag      = st_r.wake_flag;
	assign rx_fault_flag      = st_r.rx_fault;
	assign restart_req        = st_r.restart;
	assign mcu_supply_rail    = !low_power_chip || st_r.supply_ramp;

	// helper: run length of bus activity
	logic [FILT_W:0] act_run_r;
	always_ff @(posedge clk)
	begin
		if (!rst_b || !bus_activity)
			act_run_r <= '0;
		else if (act_run_r != '1)
			act_run_r <= act_run_r + 1'b1;
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	sequence s_wake_in(chip_mode_type c);
		wake_hit && chip_mode == c;
	endsequence

	sequence s_wake_out;
		bus_wake_flag && !bus_receive_output;
	endsequence

	property p_drive;
		xcvr_mode == X_NORMAL |=> bus_drive_dominant == !$past(bus_transmit_input);
	endproperty
	a_drive : assert property (p_drive) else $error("bus drive not following tx");

	property p_rxonly;
		xcvr_mode == X_RXONLY |=> !bus_drive_dominant;
	endproperty
	a_rxonly : assert property (p_rxonly) else $error("driver active in rx only");

	property p_split;
		(xcvr_mode == X_OFF || xcvr_mode == X_WAKE) |-> !split_enable && !driver_enable;
	endproperty
	a_split : assert property (p_split) else $error("split on in low power mode");

	property p_filter;
		$rose(bus_wake_flag) |-> $past(bus_activity)
			&& $past(act_run_r) >= (FILT_W+1)'(WAKE_FILT_CYC);
	endproperty
	a_filter : assert property (p_filter) else $error("wake accepted too early");

	property p_sleep_wake;
		s_wake_in(C_SLEEP) |=> s_wake_out and restart_req and int_b and mcu_supply_rail;
	endproperty
	a_sleep_wake : assert property (p_sleep_wake) else $error("sleep wake response");

	property p_stop_wake;
		s_wake_in(C_STOP) and !wake_mask |=> s_wake_out and !int_b and !restart_req;
	endproperty
	a_stop_wake : assert property (p_stop_wake) else $error("stop wake response");

	property p_fs_wake;
		s_wake_in(C_FAILSAFE) |=> s_wake_out and int_b and restart_req;
	endproperty
	a_fs_wake : assert property (p_fs_wake) else $error("fail-safe wake response");

	property p_masked;
		wake_hit && wake_mask && int_b |=> int_b;
	endproperty
	a_masked : assert property (p_masked) else $error("masked wake drove int");

	property p_off_ignore;
		xcvr_mode == X_OFF |=> !$rose(bus_wake_flag);
	endproperty
	a_off_ignore : assert property (p_off_ignore) else $error("wake in off mode");

	property p_forced;
		chip_mode == C_FAILSAFE |=> xcvr_mode == X_WAKE;
	endproperty
	a_forced : assert property (p_forced) else $error("fail-safe not wake capable");

	property p_reject;
		mode_req_valid && chip_mode != C_FAILSAFE && chip_mode != C_INIT
			&& chip_mode != C_FACTORY_FLASH && !mode_allowed(chip_mode, mode_req, st_r.armed)
			|=> xcvr_mode == $past(xcvr_mode) && mode_req_reject;
	endproperty
	a_reject : assert property (p_reject) else $error("illegal mode taken");

	property p_normal_cmd;
		$changed(xcvr_mode) && xcvr_mode == X_NORMAL |-> $past(mode_req_valid);
	endproperty
	a_normal_cmd : assert property (p_normal_cmd) else $error("normal without command");

	property p_rx_fault;
		rx_active(xcvr_mode) && rx_pin_sense != bus_receive_output |=> rx_fault_flag;
	endproperty
	a_rx_fault : assert property (p_rx_fault) else $error("rx fault missed");

	property p_baud;
		baud_tick |=> !baud_tick [*8];
	endproperty
	a_baud : assert property (p_baud) else $error("sample pacing too fast");
endmodule

//--- can_node_model.sv
// far-side model: protocol controller, bus loopback and monitor drain
// assumes the bench sets the command inputs away from the rising edge
`timescale 1ns/1ps
module can_node_model
(
	input  wire logic tx_dom,             // controller sends dominant
	input  wire logic fault,              // break receive pin readback
	input  wire logic act,                // foreign node activity
	input  wire logic stall,              // hold off monitor drain
	input  wire logic bus_drive_dominant, // transceiver drives bus
	input  wire logic bus_receive_output, // receive pin from transceiver
	output logic      bus_transmit_input, // controller tx, 0 dominant
	output logic      bus_rx_level,       // comparator level
	output logic      bus_activity,       // low-power receiver level
	output logic      rx_pin_sense,       // receive pin on the wire
	output logic      mon_ready           // drain accepts
);
	assign bus_transmit_input = ~tx_dom;
	// wired bus: any dominant driver wins
	assign bus_rx_level = ~(bus_drive_dominant | act);
	assign bus_activity = act;
	assign rx_pin_sense = bus_receive_output ^ fault;
	assign mon_ready = ~stall;
endmodule

//--- can_transceiver_mode_wake_control_tb.sv
// self-checking bench for transceiver mode and wake control
// assumes can_node_model on the far side and one 50 MHz clock
`timescale 1ns/1ps
module can_transceiver_mode_wake_control_tb;
	import can_xcvr_pkg::*;
	logic clk = 0, rst_b = 0, mode_req_valid = 0, wake_mask = 0;
	logic wake_flag_clear = 0, rx_fault_clear = 0;
	logic tx_dom = 0, fault = 0, act = 0, stall = 0;
	chip_mode_type chip_mode = C_NORMAL;
	xcvr_mode_type mode_req = X_OFF;
	wire xcvr_mode_type xcvr_mode;
	wire bus_transmit_input, bus_rx_level, bus_activity, rx_pin_sense;
	wire mode_req_reject, driver_enable, receiver_enable, split_enable;
	wire bus_drive_dominant, bus_receive_output, int_b, bus_wake_flag;
	wire rx_fault_flag, restart_req, mcu_supply_rail, mon_valid, mon_ready;
	wire [1:0] mon_data;
	int error_cnt = 0, samples_checked = 0, cyc = 0;

	can_transceiver_mode_wake_control dut (.clk, .rst_b, .chip_mode, .mode_req,
		.mode_req_valid, .wake_mask, .wake_flag_clear, .rx_fault_clear,
		.bus_transmit_input, .bus_rx_level, .bus_activity, .rx_pin_sense,
		.xcvr_mode, .mode_req_reject, .driver_enable, .receiver_enable,
		.split_enable, .bus_drive_dominant, .bus_receive_output, .int_b,
		.bus_wake_flag, .rx_fault_flag, .restart_req, .mcu_supply_rail,
		.mon_data, .mon_valid, .mon_ready);
	can_node_model node (.tx_dom, .fault, .act, .stall, .bus_drive_dominant,
		.bus_receive_output, .bus_transmit_input, .bus_rx_level,
		.bus_activity, .rx_pin_sense, .mon_ready);

	always #10 clk = ~clk;

	task stop_test;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			error_cnt++;
			stop_test;
		end
	end

	task chk(input string n, input logic [7:0] e, input logic [7:0] s);
		samples_checked++;
		if (s !== e)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", n, e, s);
		end
	endtask

	task tick(input int n);
		repeat (n) @(negedge clk);
	endtask

	// idle cycle first keeps back-to-back requests apart
	task ask(input chip_mode_type c, input xcvr_mode_type m);
		tick(1);
		chip_mode = c;
		mode_req = m;
		mode_req_valid = 1;
		tick(1);
		mode_req_valid = 0;
	endtask

	// idle cycle, then activity on n rising edges; answer stands at return
	task wake(input int n);
		tick(1);
		act = 1;
		tick(n);
		act = 0;
	endtask

	task wclr;
		wake_flag_clear = 1;
		tick(1);
		wake_flag_clear = 0;
		chk("flag", 0, bus_wake_flag);
		chk("int", 1, int_b);
	endtask

	task t_modes;
		ask(C_NORMAL, X_NORMAL);
		chk("mode", X_NORMAL, xcvr_mode);
		chk("drv", 1, driver_enable);
		chk("split", 1, split_enable);
		tx_dom = 1;
		tick(3);
		chk("dom", 1, bus_drive_dominant);
		chk("rxo", 0, bus_receive_output);
		tx_dom = 0;
		ask(C_NORMAL, X_RXONLY);
		chk("drv", 0, driver_enable);
		chk("rcv", 1, receiver_enable);
		chk("split", 1, split_enable);
		tx_dom = 1;
		tick(3);
		chk("dom", 0, bus_drive_dominant);
		tx_dom = 0;
		fault = 1;
		tick(2);
		fault = 0;
		chk("fault", 1, rx_fault_flag);
		rx_fault_clear = 1;
		tick(1);
		rx_fault_clear = 0;
		chk("fault", 0, rx_fault_flag);
		ask(C_SW_FLASH, X_OFF);
		chk("rej", 1, mode_req_reject);
		chk("mode", X_RXONLY, xcvr_mode);
		ask(C_SW_FLASH, X_NORMAL);
		chk("mode", X_NORMAL, xcvr_mode);
		chip_mode = C_FACTORY_FLASH;
		tick(2);
		chk("mode", X_OFF, xcvr_mode);
		ask(C_SW_DEV, X_NORMAL);
		chk("mode", X_NORMAL, xcvr_mode);
		chip_mode = C_INIT;
		tick(2);
		chk("mode", X_OFF, xcvr_mode);
		chip_mode = C_FAILSAFE;
		tick(2);
		chk("mode", X_WAKE, xcvr_mode);
		chk("split", 0, split_enable);
		wake(51);
		chk("restart", 1, restart_req);
		chk("int", 1, int_b);
		chk("rxo", 0, bus_receive_output);
		chip_mode = C_RESTART;
		wclr;
		$display("t_modes done");
	endtask

	task t_stop;
		ask(C_STOP, X_OFF);
		ask(C_STOP, X_NORMAL);
		chk("rej", 1, mode_req_reject);
		chk("mode", X_OFF, xcvr_mode);
		ask(C_STOP, X_WAKE);
		chk("mode", X_WAKE, xcvr_mode);
		wake(50);
		chk("flag", 0, bus_wake_flag);
		wake(51);
		chk("flag", 1, bus_wake_flag);
		chk("int", 0, int_b);
		chk("rxo", 0, bus_receive_output);
		chk("restart", 0, restart_req);
		chk("mode", X_WAKE, xcvr_mode);
		ask(C_STOP, X_WAKE);
		chk("rej", 1, mode_req_reject);
		wclr;
		ask(C_STOP, X_OFF);
		ask(C_STOP, X_WAKE);
		chk("rej", 0, mode_req_reject);
		ask(C_STOP, X_OFF);
		wake(60);
		chk("flag", 0, bus_wake_flag);
		$display("t_stop done");
	endtask

	task t_sleep_normal;
		ask(C_SLEEP, X_WAKE);
		chk("supply", 0, mcu_supply_rail);
		wake(51);
		chk("restart", 1, restart_req);
		chk("int", 1, int_b);
		chk("flag", 1, bus_wake_flag);
		chk("rxo", 0, bus_receive_output);
		chk("supply", 1, mcu_supply_rail);
		chip_mode = C_RESTART;
		wclr;
		ask(C_NORMAL, X_OFF);
		ask(C_NORMAL, X_WAKE);
		wake_mask = 1;
		wake(51);
		chk("flag", 1, bus_wake_flag);
		chk("int", 1, int_b);
		wclr;
		wake_mask = 0;
		ask(C_NORMAL, X_OFF);
		ask(C_NORMAL, X_WAKE);
		wake(51);
		chk("int", 0, int_b);
		chk("rxo", 0, bus_receive_output);
		chk("mode", X_WAKE, xcvr_mode);
		chk("restart", 0, restart_req);
		wclr;
		$display("t_sleep_normal done");
	endtask

	task t_fifo;
		int n;
		n = 0;
		stall = 1;
		tx_dom = 1;
		ask(C_NORMAL, X_RXONLY);
		tick(1000);
		chk("mvalid", 1, mon_valid);
		ask(C_NORMAL, X_OFF);
		tick(60);
		stall = 0;
		tx_dom = 0;
		repeat (60)
		begin
			if (mon_valid === 1'b1)
			begin
				n++;
				// rx recessive, tx dominant
				chk("mdata", 8'h02, mon_data);
			end
			tick(1);
		end
		// sixteen stored plus the stalled holding word
		chk("words", 8'h11, n[7:0]);
		$display("t_fifo done");
	endtask

	initial
	begin
		tick(4);
		chk("mode", X_OFF, xcvr_mode);
		chk("int", 1, int_b);
		chk("rxo", 1, bus_receive_output);
		chk("flag", 0, bus_wake_flag);
		chk("mvalid", 0, mon_valid);
		rst_b = 1;
		tick(1);
		t_modes;
		t_stop;
		t_sleep_normal;
		t_fifo;
		stop_test;
	end
endmodule
